// File: tb/cpc_chk.sv
// cpc_chk: pin-level properties of the codec link, watched on cpc_if.
// Assumes one clock domain; inputs are the interface signals themselves.
`timescale 1ns/1ns
`default_nettype none
module cpc_chk import cpc_pkg::*; (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic serial_frame_marker,
   input wire logic codec_reset_n,
   input wire logic power_save_n,
   input wire logic factory_test_enable,
   input wire logic format_extend_select,
   input wire logic ser_data_out_oe,
   input wire logic [GPIO_N-1:0] gen_output,
   input wire logic [GPIO_N-1:0] gen_output_oe,
   input wire logic test_sync_out,
   input wire logic test_sync_out_oe
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [3:0] psn_lo_r, ext_lo_r, tst_lo_r, rst_lo_r;
   logic [9:0] gap_r, oe_run_r;
   logic mark_q_r, seen_r;
   // saturating count of cycles a pin has stayed low
   function automatic logic [3:0] lo_cnt(input logic [3:0] c, input logic pin);
      return pin ? 4'h0 : ((c == 4'hF) ? c : c + 4'h1);
   endfunction : lo_cnt
   // how long each control pin has been low
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         psn_lo_r <= 4'h0;
         ext_lo_r <= 4'h0;
         tst_lo_r <= 4'h0;
         rst_lo_r <= 4'h0;
      end else begin
         psn_lo_r <= lo_cnt(psn_lo_r, power_save_n);
         ext_lo_r <= lo_cnt(ext_lo_r, format_extend_select);
         tst_lo_r <= lo_cnt(tst_lo_r, factory_test_enable);
         rst_lo_r <= lo_cnt(rst_lo_r, codec_reset_n);
      end
   end
   // cycles since the last marker rise; first rise after any reset only arms
   always_ff @(posedge clk_i) begin
      mark_q_r <= nrst_i & serial_frame_marker;
      if (!nrst_i || !codec_reset_n) begin
         seen_r <= 1'b0;
         gap_r <= 10'h000;
      end else if (serial_frame_marker && !mark_q_r) begin
         seen_r <= 1'b1;
         gap_r <= 10'h000;
      end else begin
         gap_r <= gap_r + 10'h001;
      end
   end
   // length of the current data-enable window
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !ser_data_out_oe) begin
         oe_run_r <= 10'h000;
      end else begin
         oe_run_r <= oe_run_r + 10'h001;
      end
   end
   sequence mark_bit_s;
      serial_frame_marker [*8] ##1 !serial_frame_marker;
   endsequence
   sequence all_float_s;
      !ser_data_out_oe && gen_output_oe == 4'h0 && !test_sync_out_oe;
   endsequence
   AST_MARK_WIDTH: assert property ($rose(serial_frame_marker) |-> mark_bit_s)
      else $error("frame marker not one bit period wide");
   AST_MARK_PERIOD: assert property (serial_frame_marker && !mark_q_r && seen_r |-> gap_r == 10'h3FF)
      else $error("frame marker spacing is not 128 bits");
   AST_RESET_QUIET: assert property (rst_lo_r >= 4'h4 |-> all_float_s ##0 gen_output == GOUT_RST)
      else $error("codec drives pins while held in reset");
   AST_LOWPWR_FLOAT: assert property (psn_lo_r >= 4'h8 |-> all_float_s)
      else $error("pins driven in low or zero power");
   AST_LOWPWR_HOLD: assert property (psn_lo_r >= 4'h8 && codec_reset_n |-> $stable(gen_output))
      else $error("general outputs changed in low power");
   AST_TEST_OE: assert property (tst_lo_r >= 4'h8 |-> !test_sync_out_oe)
      else $error("test sync driven outside production test");
   AST_TEST_PULSE: assert property ($rose(test_sync_out) |=> !test_sync_out)
      else $error("test sync pulse longer than one clock");
   AST_COMPAT_OUT4: assert property (ext_lo_r >= 4'h8 && codec_reset_n
      |-> !gen_output_oe[3] && $stable(gen_output[3]))
      else $error("output four used in compatible format");
   AST_SLOT_SPAN: assert property (oe_run_r <= 10'h100)
      else $error("data enable longer than one slot");
endmodule : cpc_chk
`default_nettype wire

// File: tb/tb.sv
// tb: host end and codec end joined by cpc_if, driven from their user sides.
// Assumes a 50 MHz clock; the host end makes the 160 ns bit clock.
`timescale 1ns/1ns
`default_nettype none
module tb import cpc_pkg::*;;
   logic clk_i, nrst_i, run, psn, tst, ext, cvld, crdy, pvld, hvld, algn;
   logic [1:0] slot;
   logic [3:0] bin, gout, gin;
   logic [15:0] pdat, cdat, pout, hdat;
   cpc_mode_t mode;
   int failures, checks;
   cpc_if bus ();
   cpc_host_end cpc_host_end_i (.clk_i(clk_i), .nrst_i(nrst_i), .pins(bus.host), .codec_run_i(run),
      .power_save_n_i(psn), .test_enable_i(tst), .ext_format_i(ext), .slot_sel_i(slot),
      .board_in_i(bin), .play_data_i(pdat), .gout_i(gout), .play_taken_o(),
      .cap_data_o(hdat), .gin_o(gin), .cap_valid_o(hvld));
   cpc_codec_end #(.FIFO_DEPTH(16)) cpc_codec_end_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .pins(bus.dev), .cap_data_i(cdat), .cap_valid_i(cvld), .cap_ready_o(crdy),
      .play_data_o(pout), .play_valid_o(pvld), .mode_o(mode), .aligned_o(algn));
   cpc_chk cpc_chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .serial_frame_marker(bus.serial_frame_marker),
      .codec_reset_n(bus.codec_reset_n), .power_save_n(bus.power_save_n),
      .factory_test_enable(bus.factory_test_enable),
      .format_extend_select(bus.format_extend_select), .ser_data_out_oe(bus.ser_data_out_oe),
      .gen_output(bus.gen_output), .gen_output_oe(bus.gen_output_oe),
      .test_sync_out(bus.test_sync_out), .test_sync_out_oe(bus.test_sync_out_oe));
   // counts, verdict and end of run
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
      cmp({12'h000, got}, {12'h000, exp});
   endtask : cmp4
   task automatic ticks(input int n);
      repeat (n) @(negedge clk_i);
   endtask : ticks
   // bounded wait for a one-clock pulse: playback word or capture word
   task automatic wait_pulse(input bit cap);
      for (int n = 0; n < 3000; n++) begin
         @(posedge clk_i);
         #1;
         if ((cap ? hvld : pvld) === 1'b1) return;
      end
      failures++;
      wrap_up();
   endtask : wait_pulse
   // every slot in both formats: playback, outputs, inputs, empty capture
   task automatic sc_slots();
      for (int e = 0; e < 2; e++) begin
         for (int s = 3; s >= 0; s--) begin
            ticks(1);
            ext = e[0];
            slot = s[1:0];
            pdat = 16'hA5C0 + 16'(s);
            gout = 4'h8 | 4'(s);
            bin = 4'hD ^ 4'(s);
            repeat (2) wait_pulse(1'b0);
            cmp(pout, pdat);
            ticks(4);
            cmp4(bus.gen_output_line, (e == 1) ? gout : gout & COMPAT_OUT_MASK);
            repeat (2) wait_pulse(1'b1);
            cmp4(gin, (e == 1) ? bin : bin & COMPAT_IN_MASK);
            cmp(hdat, 16'h0000);
         end
      end
   endtask : sc_slots
   // fill capture FIFO past full, hold the refused word till taken, drain one a frame
   task automatic sc_fifo();
      wait_pulse(1'b1);
      for (int i = 0; i < 17; i++) begin
         ticks(1);
         cdat = 16'h3000 + 16'(i);
         cvld = 1'b1;
      end
      ticks(2);
      cmp4({3'b000, crdy}, 4'h0);
      for (int i = 0; i < 18; i++) begin
         wait_pulse(1'b1);
         cmp(hdat, (i < 17) ? 16'h3000 + 16'(i) : 16'h0000);
         ticks(1);
         cvld = 1'b0;
      end
      cmp4({3'b000, crdy}, 4'h1);
   endtask : sc_fifo
   // power-save and test-enable pairs; outputs held in low power
   task automatic sc_modes();
      logic [1:0] tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      cpc_mode_t exp [4] = '{MODE_LOW_POWER, MODE_ZERO_POWER, MODE_PROD_TEST, MODE_NORMAL};
      for (int k = 0; k < 4; k++) begin
         ticks(1);
         {psn, tst} = tab[k];
         ticks(12);
         cmp4({2'b00, mode}, {2'b00, exp[k]});
         if (k < 2) cmp4(bus.gen_output_line, 4'h0);
         if (k == 0) begin
            gout = 4'h5;
            ticks(1100);
            cmp4(bus.gen_output, 4'h8);
         end
         if (k == 1) cmp4({3'b000, algn}, 4'h0);
         if (k == 2) cmp4({3'b000, bus.test_sync_out_oe}, 4'h1);
         if (k == 2) ticks(1400);
      end
      cmp4(bus.gen_output_line, gout);
   endtask : sc_modes
   // codec reset pin clears outputs, then link realigns
   task automatic sc_reset();
      ticks(1);
      run = 1'b0;
      ticks(8);
      cmp4(bus.gen_output_line, GOUT_RST);
      cmp4({3'b000, algn}, 4'h0);
      run = 1'b1;
      repeat (2) wait_pulse(1'b0);
      cmp(pout, pdat);
   endtask : sc_reset
   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // reset, then the scenarios in turn
   initial begin
      failures = 0;
      checks = 0;
      nrst_i = 1'b0;
      {run, psn, tst, ext, cvld} = 5'h18;
      slot = 2'b00;
      bin = 4'h0;
      gout = 4'h0;
      pdat = 16'h0000;
      cdat = 16'h0000;
      ticks(6);
      nrst_i = 1'b1;
      sc_slots();
      sc_fifo();
      sc_modes();
      sc_reset();
      wrap_up();
   end
endmodule : tb
`default_nettype wire

// File: verilog/cpc_codec_end.sv
// cpc_codec_end: codec side of the pin link, with its capture sample FIFO.
// Assumes the host makes bit clock and frame marker; all pins sampled on clk_i.
`timescale 1ns/1ns
`default_nettype none

module cpc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic full;
   logic empty;
   // extra pointer bit tells full from empty
   assign empty = (wr_r == rd_r);
   assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_r[rd_r[AW-1:0]];
   // write side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_r <= '0;
      end else if (in_valid_i && !full) begin
         mem_r[wr_r[AW-1:0]] <= in_data_i;
         wr_r <= wr_r + 1'b1;
      end
   end
   // read side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_r <= '0;
      end else if (out_ready_i && !empty) begin
         rd_r <= rd_r + 1'b1;
      end
   end
endmodule : cpc_fifo

module cpc_codec_end import cpc_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   cpc_if.dev pins,
   input wire logic [SAMPLE_W-1:0] cap_data_i,
   input wire logic cap_valid_i,
   output logic cap_ready_o,
   output logic [SAMPLE_W-1:0] play_data_o,
   output logic play_valid_o,
   output cpc_mode_t mode_o,
   output logic aligned_o
);
   logic rst;
   logic [PIN_N-1:0] raw;
   logic [PIN_N-1:0] s1_r;
   logic [PIN_N-1:0] s2_r;
   logic [PIN_N-1:0] s3_r;
   logic [PIN_N-1:0] filt_r;
   logic bclk_d_r;
   logic rise;
   logic fall;
   logic [POS_W-1:0] pos_r;
   logic [POS_W-1:0] pos_nxt;
   logic [POS_W-1:0] tx_pos;
   logic aligned_r;
   logic [SLOT_SEL_W-1:0] slot_sel;
   logic io_on;
   logic [GPIO_N-1:0] in_mask;
   logic [GPIO_N-1:0] out_mask;
   logic [SLOT_BITS-1:0] rx_sh_r;
   logic [SLOT_BITS-1:0] rx_word;
   logic [SLOT_BITS-1:0] tx_sh_r;
   logic [SLOT_BITS-1:0] tx_word;
   logic [SAMPLE_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic tx_slot;
   logic [GPIO_N-1:0] gout_r;
   cpc_mode_t mode_nxt;

   // reset pin acts as a synchronous reset beside nrst_i
   assign rst = !nrst_i || !pins.codec_reset_n;

   // pin capture vector
   assign raw = {pins.gen_input, pins.slot_select_b, pins.slot_select_a,
                 pins.format_extend_select, pins.factory_test_enable, pins.power_save_n,
                 pins.ser_data_in, pins.serial_frame_marker, pins.bit_clock_in};

   // three-stage synchronisers, value taken when stages two and three agree
   generate
      for (genvar i = 0; i < PIN_N; i++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst) begin
               s1_r[i] <= SYNC_RST[i];
               s2_r[i] <= SYNC_RST[i];
               s3_r[i] <= SYNC_RST[i];
               filt_r[i] <= SYNC_RST[i];
            end else begin
               s1_r[i] <= raw[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  filt_r[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate

   // bit clock edge finder
   always_ff @(posedge clk_i) begin
      if (rst) begin
         bclk_d_r <= 1'b0;
      end else begin
         bclk_d_r <= filt_r[PIN_BCLK];
      end
   end
   assign rise = filt_r[PIN_BCLK] && !bclk_d_r;
   assign fall = !filt_r[PIN_BCLK] && bclk_d_r;

   // operating mode from power save and test enable
   always_comb begin
      if (!filt_r[PIN_PSN] && filt_r[PIN_TEST]) begin
         mode_nxt = MODE_ZERO_POWER;
      end else if (!filt_r[PIN_PSN]) begin
         mode_nxt = MODE_LOW_POWER;
      end else if (filt_r[PIN_TEST]) begin
         mode_nxt = MODE_PROD_TEST;
      end else begin
         mode_nxt = MODE_NORMAL;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst) begin
         mode_o <= MODE_NORMAL;
      end else begin
         mode_o <= mode_nxt;
      end
   end
   assign io_on = (mode_o == MODE_NORMAL) || (mode_o == MODE_PROD_TEST);

   // format and slot selection
   assign in_mask = filt_r[PIN_EXT] ? FULL_MASK : COMPAT_IN_MASK;
   assign out_mask = filt_r[PIN_EXT] ? FULL_MASK : COMPAT_OUT_MASK;
   assign slot_sel = {filt_r[PIN_SLB], filt_r[PIN_SLA]};

   // frame position, restarted by the marker on a rising bit clock edge
   assign pos_nxt = filt_r[PIN_MARK] ? '0 : POS_W'(pos_r + 1'b1);
   always_ff @(posedge clk_i) begin
      if (rst) begin
         pos_r <= POS_LAST;
         aligned_r <= 1'b0;
      end else if (mode_o == MODE_ZERO_POWER) begin
         aligned_r <= 1'b0; // frame position holds and alignment is lost
      end else if (rise) begin
         pos_r <= pos_nxt;
         if (filt_r[PIN_MARK]) begin
            aligned_r <= 1'b1;
         end
      end
   end
   assign aligned_o = aligned_r;

   // receive shifter, active slot only
   assign rx_word = {rx_sh_r[SLOT_BITS-2:0], filt_r[PIN_SER_DATA_IN]};
   always_ff @(posedge clk_i) begin
      if (rst) begin
         rx_sh_r <= '0;
      end else if (rise && pos_nxt[POS_W-1:BIT_W] == slot_sel) begin
         rx_sh_r <= rx_word;
      end
   end

   // playback and general output update at end of active slot
   always_ff @(posedge clk_i) begin
      if (rst) begin
         play_data_o <= '0;
         play_valid_o <= 1'b0;
         gout_r <= GOUT_RST;
      end else begin
         play_valid_o <= 1'b0;
         if (rise && aligned_r && mode_o != MODE_ZERO_POWER && pos_nxt[BIT_W-1:0] == LAST_BIT
             && pos_nxt[POS_W-1:BIT_W] == slot_sel) begin
            if (io_on) begin
               play_data_o <= rx_word[SAMPLE_LSB +: SAMPLE_W];
               play_valid_o <= 1'b1;
               gout_r <= (gout_r & ~out_mask) | (rx_word[GPIO_LSB +: GPIO_N] & out_mask);
            end else begin
               play_data_o <= '0;
            end
         end
      end
   end

   // capture FIFO, drained at the start of each active transmit slot
   cpc_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst),
      .in_data_i(cap_data_i),
      .in_valid_i(cap_valid_i),
      .in_ready_o(cap_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // transmit position is the one after the last rising edge
   assign tx_pos = POS_W'(pos_r + 1'b1);
   assign tx_slot = aligned_r && io_on && tx_pos[POS_W-1:BIT_W] == slot_sel;
   assign fifo_pop = fall && tx_slot && tx_pos[BIT_W-1:0] == FIRST_BIT;
   assign tx_word = {(fifo_valid ? fifo_data : {SAMPLE_W{1'b0}}),
                     filt_r[PIN_GIN +: GPIO_N] & in_mask, {LOW_PAD{1'b0}}};

   // transmit shifter, changes on falling bit clock edges
   always_ff @(posedge clk_i) begin
      if (rst) begin
         tx_sh_r <= '0;
         pins.ser_data_out <= 1'b0;
         pins.ser_data_out_oe <= 1'b0;
      end else if (!io_on) begin
         pins.ser_data_out_oe <= 1'b0;
      end else if (fall) begin
         pins.ser_data_out_oe <= tx_slot;
         if (fifo_pop) begin
            pins.ser_data_out <= tx_word[SLOT_BITS-1];
            tx_sh_r <= {tx_word[SLOT_BITS-2:0], 1'b0};
         end else begin
            pins.ser_data_out <= tx_sh_r[SLOT_BITS-1];
            tx_sh_r <= {tx_sh_r[SLOT_BITS-2:0], 1'b0};
         end
      end
   end

   // general output and test sync pins
   always_ff @(posedge clk_i) begin
      if (rst) begin
         pins.gen_output <= GOUT_RST;
         pins.gen_output_oe <= '0;
         pins.test_sync_out <= 1'b0;
         pins.test_sync_out_oe <= 1'b0;
      end else begin
         pins.gen_output <= gout_r;
         pins.gen_output_oe <= io_on ? out_mask : '0;
         pins.test_sync_out <= rise && filt_r[PIN_MARK];
         pins.test_sync_out_oe <= (mode_o == MODE_PROD_TEST);
      end
   end
endmodule : cpc_codec_end
`default_nettype wire

// File: verilog/cpc_host_end.sv
// cpc_host_end: host side of the pin link; makes bit clock, marker and data.
// Assumes the codec end runs on the same clk_i and drives its data line late.
`timescale 1ns/1ns
`default_nettype none
module cpc_host_end import cpc_pkg::*; (
   input wire logic clk_i,
   input wire logic nrst_i,
   cpc_if.host pins,
   input wire logic codec_run_i,
   input wire logic power_save_n_i,
   input wire logic test_enable_i,
   input wire logic ext_format_i,
   input wire logic [SLOT_SEL_W-1:0] slot_sel_i,
   input wire logic [GPIO_N-1:0] board_in_i,
   input wire logic [SAMPLE_W-1:0] play_data_i,
   input wire logic [GPIO_N-1:0] gout_i,
   output logic play_taken_o,
   output logic [SAMPLE_W-1:0] cap_data_o,
   output logic [GPIO_N-1:0] gin_o,
   output logic cap_valid_o
);
   logic [DIV_W-1:0] div_r;
   logic bclk_r;
   logic tick;
   logic h_fall;
   logic [POS_W-1:0] hpos_r;
   logic [POS_W-1:0] hpos_nxt;
   logic [SLOT_BITS-1:0] tx_sh_r;
   logic [SLOT_BITS-1:0] tx_word;
   logic [SLOT_BITS-1:0] rx_sh_r;
   logic [SLOT_BITS-1:0] rx_word;
   logic in_slot_now;
   logic in_slot_nxt;

   // static pins and reset from flops
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pins.codec_reset_n <= 1'b0;
         pins.power_save_n <= 1'b1;
         pins.factory_test_enable <= 1'b0;
         pins.format_extend_select <= 1'b0;
         pins.slot_select_a <= 1'b0;
         pins.slot_select_b <= 1'b0;
         pins.gen_input <= '0;
      end else begin
         pins.codec_reset_n <= codec_run_i;
         pins.power_save_n <= power_save_n_i;
         pins.factory_test_enable <= test_enable_i;
         pins.format_extend_select <= ext_format_i;
         pins.slot_select_a <= slot_sel_i[0];
         pins.slot_select_b <= slot_sel_i[1];
         pins.gen_input <= board_in_i;
      end
   end

   // bit clock divider
   assign tick = (div_r == DIV_W'(BCLK_HALF_CYC - 1));
   assign h_fall = tick && bclk_r;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         div_r <= '0;
         bclk_r <= 1'b0;
      end else if (tick) begin
         div_r <= '0;
         bclk_r <= !bclk_r;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign pins.bit_clock_in = bclk_r;

   // position changes on falling edges
   assign hpos_nxt = POS_W'(hpos_r + 1'b1);
   assign in_slot_now = (hpos_r[POS_W-1:BIT_W] == slot_sel_i);
   assign in_slot_nxt = (hpos_nxt[POS_W-1:BIT_W] == slot_sel_i);
   assign tx_word = {play_data_i, gout_i, {LOW_PAD{1'b0}}};
   assign rx_word = {rx_sh_r[SLOT_BITS-2:0], pins.ser_data_line};

   // drive marker and data for the next position
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hpos_r <= POS_LAST;
         tx_sh_r <= '0;
         play_taken_o <= 1'b0;
         pins.serial_frame_marker <= 1'b0;
         pins.ser_data_in <= 1'b0;
      end else begin
         play_taken_o <= 1'b0;
         if (h_fall) begin
            hpos_r <= hpos_nxt;
            pins.serial_frame_marker <= (hpos_nxt == '0);
            if (in_slot_nxt && hpos_nxt[BIT_W-1:0] == FIRST_BIT) begin
               pins.ser_data_in <= tx_word[SLOT_BITS-1];
               tx_sh_r <= {tx_word[SLOT_BITS-2:0], 1'b0};
               play_taken_o <= 1'b1;
            end else if (in_slot_nxt) begin
               pins.ser_data_in <= tx_sh_r[SLOT_BITS-1];
               tx_sh_r <= {tx_sh_r[SLOT_BITS-2:0], 1'b0};
            end else begin
               pins.ser_data_in <= 1'b0;
            end
         end
      end
   end

   // sample codec data for the current position before moving on
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rx_sh_r <= '0;
         cap_data_o <= '0;
         gin_o <= '0;
         cap_valid_o <= 1'b0;
      end else begin
         cap_valid_o <= 1'b0;
         if (h_fall && in_slot_now) begin
            rx_sh_r <= rx_word;
            if (hpos_r[BIT_W-1:0] == LAST_BIT) begin
               cap_data_o <= rx_word[SAMPLE_LSB +: SAMPLE_W];
               gin_o <= rx_word[GPIO_LSB +: GPIO_N];
               cap_valid_o <= 1'b1;
            end
         end
      end
   end
endmodule : cpc_host_end
`default_nettype wire

// File: verilog/cpc_if.sv
// cpc_if: the pins between codec end and host end.
// Assumes pins left undriven read low, as with a weak pull-down.
`timescale 1ns/1ns
`default_nettype none
interface cpc_if;
   import cpc_pkg::*;
   logic bit_clock_in;
   logic serial_frame_marker;
   logic ser_data_in;
   logic codec_reset_n;
   logic power_save_n;
   logic factory_test_enable;
   logic format_extend_select;
   logic slot_select_a;
   logic slot_select_b;
   logic [GPIO_N-1:0] gen_input;
   logic ser_data_out;
   logic ser_data_out_oe;
   logic [GPIO_N-1:0] gen_output;
   logic [GPIO_N-1:0] gen_output_oe;
   logic test_sync_out;
   logic test_sync_out_oe;
   logic ser_data_line;
   logic [GPIO_N-1:0] gen_output_line;
   // wire levels from enables
   assign ser_data_line = ser_data_out_oe & ser_data_out;
   assign gen_output_line = gen_output_oe & gen_output;
   modport dev (
      input bit_clock_in, serial_frame_marker, ser_data_in, codec_reset_n, power_save_n,
      input factory_test_enable, format_extend_select, slot_select_a, slot_select_b, gen_input,
      output ser_data_out, ser_data_out_oe, gen_output, gen_output_oe,
      output test_sync_out, test_sync_out_oe
   );
   modport host (
      output bit_clock_in, serial_frame_marker, ser_data_in, codec_reset_n, power_save_n,
      output factory_test_enable, format_extend_select, slot_select_a, slot_select_b, gen_input,
      input ser_data_line, gen_output_line
   );
endinterface : cpc_if
`default_nettype wire

// File: verilog/cpc_pkg.sv
// cpc_pkg: constants and types shared by both ends of the codec pin link.
// Assumes one frame of four 32-bit slots and a bit clock made by the host end.
`default_nettype none
package cpc_pkg;
   // frame layout
   localparam int FRAME_BITS = 128;
   localparam int POS_W = 7;
   localparam int SLOT_BITS = 32;
   localparam int BIT_W = 5;
   localparam int SLOT_SEL_W = 2;
   localparam int SAMPLE_W = 16;
   localparam int GPIO_N = 4;
   localparam int SAMPLE_LSB = 16;
   localparam int GPIO_LSB = 12;
   localparam int LOW_PAD = 12;
   localparam logic [BIT_W-1:0] LAST_BIT = 5'h1F;
   localparam logic [BIT_W-1:0] FIRST_BIT = 5'h00;
   localparam logic [POS_W-1:0] POS_LAST = 7'h7F;
   // general pins usable in the compatible format
   localparam logic [GPIO_N-1:0] COMPAT_IN_MASK = 4'h4;
   localparam logic [GPIO_N-1:0] COMPAT_OUT_MASK = 4'h7;
   localparam logic [GPIO_N-1:0] FULL_MASK = 4'hF;
   localparam logic [GPIO_N-1:0] GOUT_RST = 4'h0;
   // synchroniser pin positions
   localparam int PIN_N = 12;
   localparam int PIN_BCLK = 0;
   localparam int PIN_MARK = 1;
   localparam int PIN_SER_DATA_IN = 2;
   localparam int PIN_PSN = 3;
   localparam int PIN_TEST = 4;
   localparam int PIN_EXT = 5;
   localparam int PIN_SLA = 6;
   localparam int PIN_SLB = 7;
   localparam int PIN_GIN = 8;
   localparam logic [PIN_N-1:0] SYNC_RST = 12'h008;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int BCLK_PERIOD_NS = 160;
   localparam int BCLK_HALF_CYC = (BCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int DIV_W = 4;
   localparam int FIFO_DEPTH_DEF = 16;
   // operating modes
   typedef enum logic [1:0] {MODE_NORMAL, MODE_LOW_POWER, MODE_ZERO_POWER, MODE_PROD_TEST} cpc_mode_t;
endpackage : cpc_pkg
`default_nettype wire
